// file: ddcsel_pkg.sv
`default_nettype none
package ddcsel_pkg;
   // ==========================================================
   // register offsets
   localparam logic [11:0] DDCSEL_OFS_CONTROL = 12'h370;
   localparam logic [11:0] DDCSEL_OFS_INPUT_EXT_DEC = 12'h371;
   localparam logic [11:0] DDCSEL_OFS_OSC_CHAN = 12'h374;
   localparam logic [11:0] DDCSEL_OFS_PHASE_UPD = 12'h375;
   // ==========================================================
   // reset values
   localparam logic [7:0] DDCSEL_RST_CONTROL = 8'h00;
   localparam logic [3:0] DDCSEL_RST_NIBBLE = 4'h0;
   localparam logic [7:0] DDCSEL_RST_RDATA = 8'h00;
   // ==========================================================
   // field positions
   localparam int DDCSEL_POS_C2R = 3;
   localparam int DDCSEL_POS_HI = 4;
   // ==========================================================
   // primary decimation codes
   localparam logic [2:0] DDCSEL_PRI_HB12 = 3'h0;
   localparam logic [2:0] DDCSEL_PRI_HB123 = 3'h1;
   localparam logic [2:0] DDCSEL_PRI_HB1234 = 3'h2;
   localparam logic [2:0] DDCSEL_PRI_HB1 = 3'h3;
   localparam logic [2:0] DDCSEL_PRI_TB_1 = 3'h4;
   localparam logic [2:0] DDCSEL_PRI_TB_12 = 3'h5;
   localparam logic [2:0] DDCSEL_PRI_TB_123 = 3'h6;
   localparam logic [2:0] DDCSEL_PRI_EXT = 3'h7;
   // extended decimation codes
   localparam logic [3:0] DDCSEL_EXT_TB_1234 = 4'h0;
   localparam logic [3:0] DDCSEL_EXT_FB_1 = 4'h2;
   localparam logic [3:0] DDCSEL_EXT_FB_12 = 4'h3;
   localparam logic [3:0] DDCSEL_EXT_FB_123 = 4'h4;
   // ==========================================================
   // channel select modes
   localparam logic [3:0] DDCSEL_MODE_REG = 4'h0;
   localparam logic [3:0] DDCSEL_MODE_PINS = 4'h3;
   localparam logic [3:0] DDCSEL_MODE_EDGE0 = 4'h8;
   localparam logic [3:0] DDCSEL_MODE_EDGE1 = 4'h9;
   // ==========================================================
   // register bus request
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ddcsel_bus_t;
   // decimation chain configuration
   typedef struct packed {
      logic halfband_stage_first;
      logic halfband_stage_second;
      logic halfband_stage_third;
      logic halfband_stage_fourth;
      logic thirdband_stage;
      logic fifthband_stage;
      logic real_only;
      logic valid;
      logic [5:0] ratio;
   } ddcsel_dec_t;
endpackage
`default_nettype wire

// file: ddcsel_top.sv
`timescale 1ns/100ps
`default_nettype none
module ddcsel_top
   import ddcsel_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port
   input wire ddcsel_bus_t bus,
   output logic [7:0] rdata,
   // auxiliary pins
   input wire logic aux_pin_zero,
   input wire logic aux_pin_one,
   // phase update control
   input wire logic phase_update_continuous,
   input wire logic chip_transfer,
   // results
   output ddcsel_dec_t dec_cfg,
   output logic [3:0] numeric_oscillator_channel,
   output logic [3:0] phase_update_channel,
   output logic phase_update_apply
);
   // ==========================================================
   // registers
   logic [7:0] control;
   logic [3:0] ext_dec;
   logic [3:0] chan_mode;
   logic [3:0] chan_sel;
   logic [3:0] phase_index;
   logic [2:0] pri_dec;
   logic real_only;

   assign pri_dec = control[2:0];
   assign real_only = control[DDCSEL_POS_C2R];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         control <= DDCSEL_RST_CONTROL;
         ext_dec <= DDCSEL_RST_NIBBLE;
         chan_mode <= DDCSEL_RST_NIBBLE;
         chan_sel <= DDCSEL_RST_NIBBLE;
         phase_index <= DDCSEL_RST_NIBBLE;
      end else if (bus.wr) begin
         unique case (bus.addr)
            DDCSEL_OFS_CONTROL: begin
               control <= bus.wdata;
            end
            DDCSEL_OFS_INPUT_EXT_DEC: begin
               ext_dec <= bus.wdata[7:4];
            end
            DDCSEL_OFS_OSC_CHAN: begin
               chan_mode <= bus.wdata[7:4];
               chan_sel <= bus.wdata[3:0];
            end
            DDCSEL_OFS_PHASE_UPD: begin
               phase_index <= bus.wdata[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // read data, one cycle after the strobe
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = DDCSEL_RST_RDATA;
      if (bus.rd) begin
         unique case (bus.addr)
            DDCSEL_OFS_CONTROL: begin
               next_rdata = control;
            end
            DDCSEL_OFS_INPUT_EXT_DEC: begin
               next_rdata = {ext_dec, DDCSEL_RST_NIBBLE};
            end
            DDCSEL_OFS_OSC_CHAN: begin
               next_rdata = {chan_mode, chan_sel};
            end
            DDCSEL_OFS_PHASE_UPD: begin
               next_rdata = {DDCSEL_RST_NIBBLE, phase_index};
            end
            default: begin
               next_rdata = DDCSEL_RST_RDATA;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= DDCSEL_RST_RDATA;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // decimation chain decode
   ddcsel_dec_t next_dec;
   logic [5:0] ratio_complex;

   always_comb begin
      next_dec = '0;
      ratio_complex = 6'h00;
      next_dec.valid = 1'b1;
      next_dec.halfband_stage_first = 1'b1;
      unique case (pri_dec)
         DDCSEL_PRI_HB12: begin
            next_dec.halfband_stage_second = 1'b1;
            ratio_complex = 6'h04;
         end
         DDCSEL_PRI_HB123: begin
            next_dec.halfband_stage_second = 1'b1;
            next_dec.halfband_stage_third = 1'b1;
            ratio_complex = 6'h08;
         end
         DDCSEL_PRI_HB1234: begin
            next_dec.halfband_stage_second = 1'b1;
            next_dec.halfband_stage_third = 1'b1;
            next_dec.halfband_stage_fourth = 1'b1;
            ratio_complex = 6'h10;
         end
         DDCSEL_PRI_HB1: begin
            ratio_complex = 6'h02;
         end
         DDCSEL_PRI_TB_1: begin
            next_dec.thirdband_stage = 1'b1;
            ratio_complex = 6'h06;
         end
         DDCSEL_PRI_TB_12: begin
            next_dec.halfband_stage_second = 1'b1;
            next_dec.thirdband_stage = 1'b1;
            ratio_complex = 6'h0c;
         end
         DDCSEL_PRI_TB_123: begin
            next_dec.halfband_stage_second = 1'b1;
            next_dec.halfband_stage_third = 1'b1;
            next_dec.thirdband_stage = 1'b1;
            ratio_complex = 6'h18;
         end
         DDCSEL_PRI_EXT: begin
            // extended field only consulted here
            unique case (ext_dec)
               DDCSEL_EXT_TB_1234: begin
                  next_dec.halfband_stage_second = 1'b1;
                  next_dec.halfband_stage_third = 1'b1;
                  next_dec.halfband_stage_fourth = 1'b1;
                  next_dec.thirdband_stage = 1'b1;
                  ratio_complex = 6'h30;
               end
               DDCSEL_EXT_FB_1: begin
                  next_dec.fifthband_stage = 1'b1;
                  ratio_complex = 6'h0a;
               end
               DDCSEL_EXT_FB_12: begin
                  next_dec.fifthband_stage = 1'b1;
                  next_dec.halfband_stage_second = 1'b1;
                  ratio_complex = 6'h14;
               end
               DDCSEL_EXT_FB_123: begin
                  next_dec.fifthband_stage = 1'b1;
                  next_dec.halfband_stage_second = 1'b1;
                  next_dec.halfband_stage_third = 1'b1;
                  ratio_complex = 6'h28;
               end
               default: begin
                  // undefined code: no chain, flagged invalid
                  next_dec.valid = 1'b0;
                  next_dec.halfband_stage_first = 1'b0;
               end
            endcase
         end
      endcase
      next_dec.real_only = real_only;
      // real output runs at twice the complex rate
      next_dec.ratio = real_only ? {1'b0, ratio_complex[5:1]} : ratio_complex;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dec_cfg <= '0;
      end else begin
         dec_cfg <= next_dec;
      end
   end

   // ==========================================================
   // auxiliary pin synchronisers and edge detect
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic [1:0] pin_last;
   logic [1:0] pin_rise;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pin_last <= 2'h0;
      end else begin
         pin_meta <= {aux_pin_one, aux_pin_zero};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // only the second and third stages feed the detector
   assign pin_rise = pin_sync & ~pin_last;

   // ==========================================================
   // channel counter
   logic [3:0] edge_count;
   logic count_step;

   always_comb begin
      count_step = 1'b0;
      if (chan_mode == DDCSEL_MODE_EDGE0) begin
         count_step = pin_rise[0];
      end else if (chan_mode == DDCSEL_MODE_EDGE1) begin
         count_step = pin_rise[1];
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         edge_count <= 4'h0;
      end else if (count_step) begin
         // wrap also catches a limit lowered below the count
         if (edge_count >= chan_sel) begin
            edge_count <= 4'h0;
         end else begin
            edge_count <= edge_count + 4'h1;
         end
      end
   end

   // ==========================================================
   // active channel select
   logic [3:0] next_channel;

   always_comb begin
      unique case (chan_mode)
         DDCSEL_MODE_PINS: begin
            next_channel = {2'h0, pin_sync[1], pin_sync[0]};
         end
         DDCSEL_MODE_EDGE0, DDCSEL_MODE_EDGE1: begin
            next_channel = edge_count;
         end
         default: begin
            next_channel = chan_sel;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         numeric_oscillator_channel <= 4'h0;
      end else begin
         numeric_oscillator_channel <= next_channel;
      end
   end

   // ==========================================================
   // phase update target and apply
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase_update_channel <= 4'h0;
         phase_update_apply <= 1'b0;
      end else begin
         phase_update_channel <= phase_index;
         // continuous mode holds apply; else one pulse per transfer
         phase_update_apply <= phase_update_continuous | chip_transfer;
      end
   end

   // ==========================================================
   // checks
   sequence s_pri(logic [2:0] c, logic r);
      pri_dec == c && real_only == r;
   endsequence

   sequence s_ext(logic [3:0] c, logic r);
      pri_dec == DDCSEL_PRI_EXT && ext_dec == c && real_only == r;
   endsequence

   AST_PRI_100: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_pri(3'h4, 1'b0) |=> dec_cfg.ratio == 6'h06 && dec_cfg.thirdband_stage && !dec_cfg.halfband_stage_second)
      else $error("code 100 chain wrong");

   AST_PRI_101: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_pri(3'h5, 1'b1) |=> dec_cfg.ratio == 6'h06 && dec_cfg.thirdband_stage && dec_cfg.halfband_stage_second)
      else $error("code 101 chain wrong");

   AST_PRI_110: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_pri(3'h6, 1'b0) |=> dec_cfg.ratio == 6'h18 && dec_cfg.halfband_stage_third)
      else $error("code 110 chain wrong");

   AST_EXT_IGNORED: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pri_dec != DDCSEL_PRI_EXT && $stable(control) && $changed(ext_dec) |=> $stable(dec_cfg))
      else $error("extended field leaked");

   AST_EXT_0: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_ext(4'h0, 1'b0) |=> dec_cfg.ratio == 6'h30 && dec_cfg.halfband_stage_fourth && dec_cfg.thirdband_stage)
      else $error("extended 0 chain wrong");

   AST_EXT_2: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_ext(4'h2, 1'b1) |=> dec_cfg.ratio == 6'h05 && dec_cfg.fifthband_stage && !dec_cfg.halfband_stage_second)
      else $error("extended 2 chain wrong");

   AST_EXT_3: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_ext(4'h3, 1'b1) |=> dec_cfg.ratio == 6'h0a && dec_cfg.fifthband_stage && dec_cfg.halfband_stage_second)
      else $error("extended 3 chain wrong");

   AST_EXT_4: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_ext(4'h4, 1'b0) |=> dec_cfg.ratio == 6'h28 && dec_cfg.fifthband_stage && dec_cfg.halfband_stage_third)
      else $error("extended 4 chain wrong");

   AST_MODE_REG: assert property (@(posedge clk_sys) disable iff (sys_rst)
      chan_mode == DDCSEL_MODE_REG |=> numeric_oscillator_channel == $past(chan_sel))
      else $error("register select not followed");

   AST_MODE_PINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      chan_mode == DDCSEL_MODE_PINS |=> numeric_oscillator_channel == {2'h0, $past(pin_sync)})
      else $error("pin select wrong");

   AST_EDGE_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      chan_mode == DDCSEL_MODE_EDGE0 && pin_rise[0] && edge_count < chan_sel
      |=> edge_count == $past(edge_count) + 4'h1)
      else $error("edge not counted");

   AST_EDGE_STEP_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      chan_mode == DDCSEL_MODE_EDGE1 && pin_rise[1] && edge_count < chan_sel
      |=> edge_count == $past(edge_count) + 4'h1)
      else $error("pin one edge not counted");

   AST_EDGE_WRAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      count_step && edge_count >= chan_sel |=> edge_count == 4'h0)
      else $error("counter did not wrap");

   AST_EDGE_ONCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pin_rise[0] |-> $past(aux_pin_zero, 2) && !$past(aux_pin_zero, 3))
      else $error("edge not from one pin rise");

   AST_PHASE_IDX: assert property (@(posedge clk_sys) disable iff (sys_rst)
      bus.wr && bus.addr == DDCSEL_OFS_PHASE_UPD ##2 1'b1 |-> phase_update_channel == $past(bus.wdata[3:0], 2))
      else $error("update index not applied");

   AST_PHASE_APPLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !phase_update_continuous |=> phase_update_apply == $past(chip_transfer))
      else $error("transfer apply pulse wrong");
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import ddcsel_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   ddcsel_bus_t bus = '0;
   logic aux_pin_zero = 1'b0;
   logic aux_pin_one = 1'b0;
   logic phase_update_continuous = 1'b0;
   logic chip_transfer = 1'b0;
   logic [7:0] rdata;
   ddcsel_dec_t dec_cfg;
   logic [3:0] numeric_oscillator_channel;
   logic [3:0] phase_update_channel;
   logic phase_update_apply;
   int num_errors = 0;
   int comparisons = 0;
   logic [7:0] rd_val;
   // stage masks {hb1,hb2,hb3,hb4,tb,fb}: primary 0..6, then extended 0,2,3,4
   localparam logic [5:0] STG [11] = '{6'h30, 6'h38, 6'h3c, 6'h20, 6'h22, 6'h32, 6'h3a,
      6'h3e, 6'h21, 6'h31, 6'h39};
   localparam logic [5:0] RAT [11] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0c, 6'h18,
      6'h30, 6'h0a, 6'h14, 6'h28};
   localparam logic [3:0] EXTC [4] = '{4'h0, 4'h2, 4'h3, 4'h4};
   localparam logic [11:0] ADR [5] = '{12'h370, 12'h371, 12'h374, 12'h375, 12'h372};
   localparam logic [7:0] EXPR [5] = '{8'hff, 8'hf0, 8'ha5, 8'h0f, 8'h00};
   localparam logic [7:0] WRV [5] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'hff};

   ddcsel_top i_ddcsel_top (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .bus(bus),
      .rdata(rdata),
      .aux_pin_zero(aux_pin_zero),
      .aux_pin_one(aux_pin_one),
      .phase_update_continuous(phase_update_continuous),
      .chip_transfer(chip_transfer),
      .dec_cfg(dec_cfg),
      .numeric_oscillator_channel(numeric_oscillator_channel),
      .phase_update_channel(phase_update_channel),
      .phase_update_apply(phase_update_apply)
   );

   always #5 clk_sys = ~clk_sys;

   // ==========================================================
   // helpers
   function automatic logic [15:0] exp_dec(input int idx, input logic c2r);
      ddcsel_dec_t d;
      d = '0;
      {d.halfband_stage_first, d.halfband_stage_second, d.halfband_stage_third,
         d.halfband_stage_fourth, d.thirdband_stage, d.fifthband_stage} = STG[idx];
      d.real_only = c2r;
      d.valid = 1'b1;
      // real-only output needs half the complex ratio
      d.ratio = c2r ? (RAT[idx] >> 1) : RAT[idx];
      return {2'h0, d};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   // read data only stand in the cycle after the strobe, so sample there
   task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // pin rises need a low cycle between them, so the pulse keeps six low cycles
   task automatic pulse(input logic which);
      @(posedge clk_sys);
      if (which) aux_pin_one <= 1'b1;
      else aux_pin_zero <= 1'b1;
      repeat (2) @(posedge clk_sys);
      aux_pin_one <= 1'b0;
      aux_pin_zero <= 1'b0;
      repeat (2) @(posedge clk_sys);
      wait_cyc(4);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      wait_cyc(2);
      chk(dec_cfg, exp_dec(0, 1'b0));
      chk(numeric_oscillator_channel, 4'h0);
      for (int i = 0; i < 4; i++) begin
         reg_rd(ADR[i], rd_val);
         chk(rd_val, 8'h00);
      end
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         reg_wr(ADR[i], WRV[i]);
         reg_rd(ADR[i], rd_val);
         chk(rd_val, EXPR[i]);
      end
      wait_cyc(1);
      chk(rdata, 8'h00);
      $display("test registers done");
      // extended field holds a live code to prove it is ignored
      reg_wr(DDCSEL_OFS_INPUT_EXT_DEC, 8'h20);
      for (int i = 0; i < 14; i++) begin
         reg_wr(DDCSEL_OFS_CONTROL, {4'h0, i[0], i[3:1]});
         wait_cyc(2);
         chk(dec_cfg, exp_dec(i / 2, i[0]));
      end
      // a new extended code under a primary chain must leave the chain alone
      reg_wr(DDCSEL_OFS_INPUT_EXT_DEC, 8'h40);
      wait_cyc(2);
      chk(dec_cfg, exp_dec(6, 1'b1));
      for (int i = 0; i < 8; i++) begin
         reg_wr(DDCSEL_OFS_INPUT_EXT_DEC, {EXTC[i / 2], 4'h0});
         reg_wr(DDCSEL_OFS_CONTROL, {4'h0, i[0], 3'h7});
         wait_cyc(2);
         chk(dec_cfg, exp_dec(7 + i / 2, i[0]));
      end
      reg_wr(DDCSEL_OFS_INPUT_EXT_DEC, 8'h10);
      wait_cyc(2);
      chk({dec_cfg.valid, dec_cfg.ratio}, 16'h0000);
      $display("test decimation done");
      for (int i = 0; i < 16; i++) begin
         reg_wr(DDCSEL_OFS_OSC_CHAN, {4'h0, i[3:0]});
         wait_cyc(2);
         chk(numeric_oscillator_channel, i[3:0]);
      end
      reg_wr(DDCSEL_OFS_OSC_CHAN, 8'h5a);
      wait_cyc(2);
      chk(numeric_oscillator_channel, 4'ha);
      reg_wr(DDCSEL_OFS_OSC_CHAN, 8'h30);
      aux_pin_one <= 1'b1;
      wait_cyc(5);
      chk(numeric_oscillator_channel, 4'h2);
      @(posedge clk_sys);
      aux_pin_one <= 1'b0;
      aux_pin_zero <= 1'b1;
      wait_cyc(5);
      chk(numeric_oscillator_channel, 4'h1);
      @(posedge clk_sys);
      aux_pin_zero <= 1'b0;
      $display("test channel select done");
      reg_wr(DDCSEL_OFS_OSC_CHAN, 8'h82);
      wait_cyc(5);
      chk(numeric_oscillator_channel, 4'h0);
      pulse(1'b0);
      chk(numeric_oscillator_channel, 4'h1);
      pulse(1'b0);
      chk(numeric_oscillator_channel, 4'h2);
      pulse(1'b0);
      chk(numeric_oscillator_channel, 4'h0);
      pulse(1'b0);
      pulse(1'b1);
      chk(numeric_oscillator_channel, 4'h1);
      reg_wr(DDCSEL_OFS_OSC_CHAN, 8'h92);
      pulse(1'b0);
      pulse(1'b1);
      chk(numeric_oscillator_channel, 4'h2);
      pulse(1'b1);
      chk(numeric_oscillator_channel, 4'h0);
      $display("test edge counting done");
      for (int i = 0; i < 16; i++) begin
         reg_wr(DDCSEL_OFS_PHASE_UPD, {4'hf, i[3:0]});
         wait_cyc(2);
         chk(phase_update_channel, i[3:0]);
      end
      chk(phase_update_apply, 1'b0);
      @(posedge clk_sys);
      chip_transfer <= 1'b1;
      @(posedge clk_sys);
      chip_transfer <= 1'b0;
      #1;
      chk(phase_update_apply, 1'b1);
      wait_cyc(1);
      chk(phase_update_apply, 1'b0);
      @(posedge clk_sys);
      phase_update_continuous <= 1'b1;
      wait_cyc(3);
      chk(phase_update_apply, 1'b1);
      $display("test phase update done");
      print_verdict();
   end

   // the whole sequence needs well under 2000 cycles
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
